/* hrr_pkg.sv */
// constants, codes and register map of the response record builder
// assumes one 200 MHz clock and a 32-bit Avalon-MM register port
package hrr_pkg;

  // record size in bytes, header included
  localparam int          REC_BYTES      = 240;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL       = 12'h000;
  localparam logic [11:0] OFF_STATUS     = 12'h004;
  localparam logic [11:0] OFF_MASK       = 12'h008;
  localparam logic [11:0] OFF_LEN        = 12'h00C;
  localparam logic [11:0] OFF_REC        = 12'h400;
  localparam logic [1:0]  REC_WIN        = 2'h1;

  // control register fields
  localparam int          CTRL_CLEAR_BIT = 0;
  localparam int          CTRL_FAST_BIT  = 1;

  // event bits of status and mask
  localparam int          EV_W           = 3;
  localparam int          EV_DONE_BIT    = 0;
  localparam int          EV_FAIL_BIT    = 1;
  localparam int          EV_OVF_BIT     = 2;

  // processing status codes, control byte bits 2:0
  localparam logic [2:0]  RES_INACTIVE   = 3'h0;
  localparam logic [2:0]  RES_WAIT       = 3'h2;
  localparam logic [2:0]  RES_EXEC       = 3'h3;
  localparam logic [2:0]  RES_OK_DATA    = 3'h4;
  localparam logic [2:0]  RES_OK_NODATA  = 3'h5;
  localparam logic [2:0]  RES_ERR_DATA   = 3'h6;
  localparam logic [2:0]  RES_ERR_NODATA = 3'h7;

  // group error byte fields
  localparam int          GE_MORE_BIT    = 0;
  localparam int          GE_COMM_BIT    = 1;
  localparam int          GE_PCHK_BIT    = 2;

  // protocol error classes, group error byte bits 7:4
  localparam logic [3:0]  CLS_UNSPEC     = 4'h0;
  localparam logic [3:0]  CLS_UNIT       = 4'h1;
  localparam logic [3:0]  CLS_CHAN       = 4'h2;
  localparam logic [3:0]  CLS_CMD        = 4'h3;
  localparam logic [3:0]  CLS_QUERY      = 4'h4;
  localparam logic [3:0]  CLS_RESP       = 4'h5;
  localparam logic [3:0]  CLS_REJ        = 4'h6;
  localparam logic [3:0]  CLS_PROF       = 4'h7;
  localparam logic [3:0]  CLS_MFR        = 4'h8;

  // detail byte masks, reserved bits forced low
  localparam logic [7:0]  DET_CMD_MASK   = 8'h7F;
  localparam logic [7:0]  DET_QUERY_MASK = 8'h7A;
  localparam logic [7:0]  DET_RESP_MASK  = 8'h7F;

  // header lengths ahead of the reply frame
  localparam logic [7:0]  HDR_OK         = 8'h02;
  localparam logic [7:0]  HDR_FAIL       = 8'h03;

  // reset values
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [EV_W-1:0] RST_EV     = 3'h0;

  typedef enum logic [1:0] {
    HRR_IDLE = 2'b00,
    HRR_WAIT = 2'b01,
    HRR_EXEC = 2'b10,
    HRR_DONE = 2'b11
  } hrr_state_type;

endpackage

/* hrr_buf_if.sv */
// write and read port bundle between the record builder and its frame buffer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface hrr_buf_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* hrr_frame_mem.sv */
// reply frame buffer, one write port and one registered read port
// assumes the user keeps addresses below the depth
`timescale 1ns/1ps
module hrr_frame_mem #(
  parameter int DEPTH = 240,
  parameter int AW    = 8,
  parameter int DW    = 8
) (
  input  wire logic core_clk,
  hrr_buf_if.mem    bus
);
  import hrr_pkg::*;

  logic [DW-1:0] mem_array [DEPTH];
  logic [DW-1:0] q_reg;

  // no reset on the array: contents are only read below the frame length
  always_ff @(posedge core_clk) begin
    if (bus.wr_en) begin
      mem_array[bus.wr_addr] <= bus.wr_data;
    end
    q_reg <= mem_array[bus.rd_addr];
  end

  assign bus.rd_data = q_reg;
endmodule

/* hrr_response_record.sv */
// one channel's response record: status, group error, detail and reply frame
// assumes link-side inputs are synchronous to core_clk and pulses last one cycle
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module hrr_response_record #(
  parameter int REC_DEPTH = hrr_pkg::REC_BYTES
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        req_start,
  input  wire logic        exec_start,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        reply_done,
  input  wire logic        reply_fail,
  input  wire logic [3:0]  err_class,
  input  wire logic [7:0]  err_detail,
  input  wire logic        fd_more_status,
  input  wire logic        fd_comm_err,
  input  wire logic        param_check,
  input  wire logic        fast_seq_active,
  output logic             fast_seq_req
);
  import hrr_pkg::*;

  localparam logic [7:0] FRAME_MAX = 8'(REC_DEPTH - 3);
  localparam logic [7:0] DEPTH_B   = 8'(REC_DEPTH);

  hrr_state_type   st_reg;
  hrr_state_type   st_next;
  logic [7:0]      frame_len_reg;
  logic [2:0]      result_reg;
  logic            fail_reg;
  logic [7:0]      grp_err_reg;
  logic [7:0]      detail_reg;
  logic            fast_reg;
  logic            fast_req_reg;
  logic [EV_W-1:0] ev_reg;
  logic [EV_W-1:0] mask_reg;
  logic            rd_ack_reg;

  hrr_buf_if #(.AW(8), .DW(8)) buf_if ();

  hrr_frame_mem #(
    .DEPTH (REC_DEPTH),
    .AW    (8),
    .DW    (8)
  ) u_mem (
    .core_clk (core_clk),
    .bus      (buf_if)
  );

  // bus decode
  wire       wr_lo     = avs_write & avs_byteenable[0];
  wire       rd_take   = avs_read & rd_ack_reg;
  wire       sel_ctrl  = (avs_address[11:2] == OFF_CTRL[11:2]);
  wire       sel_stat  = (avs_address[11:2] == OFF_STATUS[11:2]);
  wire       sel_mask  = (avs_address[11:2] == OFF_MASK[11:2]);
  wire       sel_len   = (avs_address[11:2] == OFF_LEN[11:2]);
  wire [7:0] rec_idx   = avs_address[9:2];
  wire       sel_rec   = (avs_address[11:10] == REC_WIN) && (rec_idx < DEPTH_B);
  wire       sw_clear  = wr_lo & sel_ctrl & avs_writedata[CTRL_CLEAR_BIT];

  // link-side events; a request start is taken in any state, the others only in the state that expects them
  wire       ev_start  = req_start;
  wire       ev_exec   = exec_start & (st_reg == HRR_WAIT) & ~req_start & ~sw_clear;
  wire       in_exec   = (st_reg == HRR_EXEC) & ~req_start & ~sw_clear;
  wire       rx_take   = in_exec & rx_valid;
  wire       rx_room   = (frame_len_reg < FRAME_MAX);
  wire       ev_done   = in_exec & reply_done;
  wire       ev_ovf    = rx_take & ~rx_room;

  // next state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      HRR_IDLE: begin
        st_next = HRR_IDLE;
      end
      HRR_WAIT: begin
        if (ev_exec) begin
          st_next = HRR_EXEC;
        end
      end
      HRR_EXEC: begin
        // final code only after the whole reply is in and checked
        if (ev_done) begin
          st_next = HRR_DONE;
        end
      end
      HRR_DONE: begin
        st_next = HRR_DONE;
      end
      default: begin
        st_next = HRR_IDLE;
      end
    endcase
    if (ev_start) begin
      st_next = HRR_WAIT;
    end else if (sw_clear) begin
      st_next = HRR_IDLE;
    end
  end

  // final result code from outcome and whether a frame arrived
  wire       has_frame = (frame_len_reg != 8'h00) | rx_take;
  wire [2:0] res_ok    = has_frame ? RES_OK_DATA : RES_OK_NODATA;
  wire [2:0] res_fail  = has_frame ? RES_ERR_DATA : RES_ERR_NODATA;
  wire [2:0] res_final = reply_fail ? res_fail : res_ok;

  // class outside 0..8 is reported as unspecified
  wire       cls_ok    = (err_class <= CLS_MFR);
  wire [3:0] cls_eff   = (reply_fail & cls_ok) ? err_class : CLS_UNSPEC;

  // detail byte per class; reserved bits and the unspecified, profile and maker classes forced to zero, other values passed unchanged
  logic [7:0] detail_next;
  always_comb begin
    detail_next = RST_BYTE;
    case (cls_eff)
      CLS_UNIT:  detail_next = err_detail;
      CLS_CHAN:  detail_next = err_detail;
      CLS_CMD:   detail_next = err_detail & DET_CMD_MASK;
      CLS_QUERY: detail_next = err_detail & DET_QUERY_MASK;
      CLS_RESP:  detail_next = err_detail & DET_RESP_MASK;
      CLS_REJ:   detail_next = err_detail;
      CLS_PROF:  detail_next = RST_BYTE;
      CLS_MFR:   detail_next = RST_BYTE;
      default:   detail_next = RST_BYTE;
    endcase
  end

  wire [7:0] grp_next = {cls_eff, 1'b0,
                         param_check,
                         fd_comm_err,
                         fd_more_status};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg        <= HRR_IDLE;
      frame_len_reg <= RST_BYTE;
      result_reg    <= RES_INACTIVE;
      fail_reg      <= 1'b0;
      grp_err_reg   <= RST_BYTE;
      detail_reg    <= RST_BYTE;
    end else begin
      st_reg <= st_next;
      if (ev_start || sw_clear) begin
        frame_len_reg <= RST_BYTE;
        grp_err_reg   <= RST_BYTE;
        detail_reg    <= RST_BYTE;
        fail_reg      <= 1'b0;
      end else begin
        if (rx_take && rx_room) begin
          frame_len_reg <= frame_len_reg + 8'h01;
        end
        if (ev_done) begin
          result_reg  <= res_final;
          fail_reg    <= reply_fail;
          grp_err_reg <= grp_next;
          detail_reg  <= reply_fail ? detail_next : RST_BYTE;
        end
      end
    end
  end

  // the frame is stored exactly as received, never reformatted
  assign buf_if.wr_en   = rx_take & rx_room;
  assign buf_if.wr_addr = frame_len_reg;
  assign buf_if.wr_data = rx_byte;

  // fast sequence flag follows the live mode, one cycle late
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fast_reg <= 1'b0;
    end else begin
      fast_reg <= fast_seq_active;
    end
  end

  // control byte as seen by the reader
  logic [2:0] status_code;
  always_comb begin
    case (st_reg)
      HRR_IDLE: status_code = RES_INACTIVE;
      HRR_WAIT: status_code = RES_WAIT;
      HRR_EXEC: status_code = RES_EXEC;
      HRR_DONE: status_code = result_reg;
      default:  status_code = RES_INACTIVE;
    endcase
  end

  // burst, source, compact and request bits are always zero
  wire [7:0] resp_ctrl = {1'b0, fast_reg, 3'h0, status_code};

  // frame position within the record depends on outcome
  wire       done_now  = (st_reg == HRR_DONE);
  wire [7:0] hdr_len   = fail_reg ? HDR_FAIL : HDR_OK;
  wire [7:0] frame_idx = rec_idx - hdr_len;
  wire       in_frame  = done_now && (rec_idx >= hdr_len) && (frame_idx < frame_len_reg);
  assign buf_if.rd_addr = frame_idx;

  logic [7:0] rec_byte;
  always_comb begin
    if (rec_idx == 8'h00) begin
      rec_byte = resp_ctrl;
    end else if (rec_idx == 8'h01) begin
      rec_byte = done_now ? grp_err_reg : RST_BYTE;
    end else if (done_now && fail_reg && rec_idx == 8'h02) begin
      rec_byte = detail_reg;
    end else if (in_frame) begin
      rec_byte = buf_if.rd_data;
    end else begin
      rec_byte = RST_BYTE;
    end
  end

  wire [7:0] rec_len = done_now ? (hdr_len + frame_len_reg) : HDR_OK;

  // registers, interrupt status cleared by reading it
  wire [EV_W-1:0] ev_set = {ev_ovf, ev_done & reply_fail, ev_done};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ev_reg       <= RST_EV;
      mask_reg     <= RST_EV;
      fast_req_reg <= 1'b0;
      rd_ack_reg   <= 1'b0;
    end else begin
      rd_ack_reg <= avs_read & ~rd_ack_reg;
      // a new event wins over the read that clears
      if (rd_take && sel_stat) begin
        ev_reg <= ev_set;
      end else begin
        ev_reg <= ev_reg | ev_set;
      end
      if (wr_lo && sel_mask) begin
        mask_reg <= avs_writedata[EV_W-1:0];
      end
      if (wr_lo && sel_ctrl) begin
        fast_req_reg <= avs_writedata[CTRL_FAST_BIT];
      end
    end
  end

  // every read takes one wait cycle so the buffer read can settle
  assign avs_waitrequest = avs_read & ~rd_ack_reg;

  wire [31:0] rd_ctrl = {30'h0, fast_req_reg, 1'b0};
  wire [31:0] rd_stat = {29'h0, ev_reg};
  wire [31:0] rd_mask = {29'h0, mask_reg};
  wire [31:0] rd_len  = {24'h0, rec_len};
  wire [31:0] rd_rec  = {24'h0, rec_byte};

  assign avs_readdata = sel_ctrl ? rd_ctrl :
                        sel_stat ? rd_stat :
                        sel_mask ? rd_mask :
                        sel_len  ? rd_len  :
                        sel_rec  ? rd_rec  : 32'h0000_0000;

  assign irq          = |(ev_reg & mask_reg);
  assign fast_seq_req = fast_req_reg;

  // checks
  a_fail_code: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_done && reply_fail && !has_frame |=> resp_ctrl[2:0] == RES_ERR_NODATA)
    else $error("failure without frame not coded 7");

  a_ok_code: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_done && !reply_fail && has_frame |=> resp_ctrl[2:0] == RES_OK_DATA)
    else $error("success with frame not coded 4");

  a_exec_code: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_exec |=> resp_ctrl[2:0] == RES_EXEC)
    else $error("executing status not 3");

  a_fixed_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    resp_ctrl[5:3] == 3'h0 && !resp_ctrl[7])
    else $error("fixed control bits not zero");

  a_fast_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(fast_seq_active) |=> !resp_ctrl[6])
    else $error("fast sequence flag stuck");

  a_more_status: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_done && fd_more_status |=> grp_err_reg[GE_MORE_BIT])
    else $error("extra status bit missing");

  a_comm_error: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_done && fd_comm_err |=> grp_err_reg[GE_COMM_BIT])
    else $error("communication error bit missing");

  a_param_check: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_done && !param_check |=> !grp_err_reg[GE_PCHK_BIT])
    else $error("parameter check bit set wrongly");

  a_class_range: assert property (@(posedge core_clk) disable iff (!resetn)
    grp_err_reg[7:4] <= CLS_MFR && !grp_err_reg[3])
    else $error("error class out of range");

  a_query_rsvd: assert property (@(posedge core_clk) disable iff (!resetn)
    grp_err_reg[7:4] == CLS_QUERY |-> (detail_reg & ~DET_QUERY_MASK) == 8'h00)
    else $error("query reserved bits set");

  a_vendor_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    ev_done && reply_fail && (err_class == CLS_PROF || err_class == CLS_MFR)
    |=> detail_reg == 8'h00)
    else $error("profile or maker class detail not zero");

  a_hold_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    in_exec && !reply_done |=> resp_ctrl[2:0] == RES_EXEC)
    else $error("final code before reply checked");

endmodule

/* hrr_link_model.sv */
// far-side model: link controller that feeds reply bytes and the outcome of a request
// assumes the bench calls its tasks right after a rising edge of core_clk
`timescale 1ns/1ps
module hrr_link_model (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       fast_seq_req,
  output logic            req_start,
  output logic            exec_start,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            reply_done,
  output logic            reply_fail,
  output logic [3:0]      err_class,
  output logic [7:0]      err_detail,
  output logic            fd_more_status,
  output logic            fd_comm_err,
  output logic            param_check,
  output logic            fast_seq_active
);
  initial begin
    req_start = 1'b0;
    exec_start = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    reply_done = 1'b0;
    reply_fail = 1'b0;
    err_class = 4'h0;
    err_detail = 8'h00;
    {param_check, fd_comm_err, fd_more_status} = 3'h0;
  end

  // fast mode follows the request one cycle later, on every channel alike
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fast_seq_active <= 1'b0;
    end else begin
      fast_seq_active <= fast_seq_req;
    end
  end

  task automatic req();
    @(posedge core_clk);
    req_start <= 1'b1;
    @(posedge core_clk);
    req_start <= 1'b0;
  endtask

  task automatic exe();
    @(posedge core_clk);
    exec_start <= 1'b1;
    @(posedge core_clk);
    exec_start <= 1'b0;
  endtask

  // idle byte lane shows the inverse, so a stale sample never looks right
  task automatic send(input int n, input logic [7:0] b, input logic slow);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte <= b + 8'(k * 37);
      if (slow) begin
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~(b + 8'(k * 37));
      end
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~(b + 8'((n - 1) * 37));
  endtask

  task automatic finish(input logic f, input logic [3:0] c, input logic [7:0] d,
                        input logic [2:0] g);
    @(posedge core_clk);
    reply_done <= 1'b1;
    reply_fail <= f;
    err_class <= c;
    err_detail <= d;
    {param_check, fd_comm_err, fd_more_status} <= g;
    @(posedge core_clk);
    reply_done <= 1'b0;
    reply_fail <= ~f;
    err_class <= ~c;
    err_detail <= ~d;
    {param_check, fd_comm_err, fd_more_status} <= ~g;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench of the response record builder
// assumes the link model drives the far side and the bench masters the register bus
`timescale 1ns/1ps
module tb_top;
  import hrr_pkg::*;
  logic        core_clk;
  logic        resetn;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        req_start;
  logic        exec_start;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        reply_done;
  logic        reply_fail;
  logic [3:0]  err_class;
  logic [7:0]  err_detail;
  logic        fd_more_status;
  logic        fd_comm_err;
  logic        param_check;
  logic        fast_seq_active;
  logic        fast_seq_req;
  int          failures;
  int          n_compared;
  logic [31:0] seed;
  logic [31:0] q;

  hrr_response_record dut (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .req_start(req_start), .exec_start(exec_start), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .reply_done(reply_done), .reply_fail(reply_fail), .err_class(err_class),
    .err_detail(err_detail), .fd_more_status(fd_more_status), .fd_comm_err(fd_comm_err),
    .param_check(param_check), .fast_seq_active(fast_seq_active), .fast_seq_req(fast_seq_req)
  );

  hrr_link_model lm (
    .core_clk(core_clk), .resetn(resetn), .fast_seq_req(fast_seq_req),
    .req_start(req_start), .exec_start(exec_start), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .reply_done(reply_done), .reply_fail(reply_fail), .err_class(err_class),
    .err_detail(err_detail), .fd_more_status(fd_more_status), .fd_comm_err(fd_comm_err),
    .param_check(param_check), .fast_seq_active(fast_seq_active)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_det(input logic [3:0] c, input logic [7:0] d);
    case (c)
      4'h1, 4'h2, 4'h6: return d;
      4'h3, 4'h5: return d & 8'h7F;
      4'h4: return d & 8'h7A;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      failures++;
      final_report();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rec(input int n);
    rd(OFF_REC + 12'(4 * n));
  endtask

  task automatic xfer(input logic f, input logic [3:0] c, input logic [7:0] d,
                      input logic [2:0] g, input int n, input logic s, input logic fs,
                      input logic [2:0] m);
    logic [7:0] b;
    logic [2:0] code;
    logic       ov;
    int         nk;
    int         hdr;
    b = 8'(xs());
    ov = n > 237;
    nk = ov ? 237 : n;
    hdr = f ? 3 : 2;
    m[0] = m[0] & ~f;
    code = f ? (n > 0 ? 3'h6 : 3'h7) : (n > 0 ? 3'h4 : 3'h5);
    wr(OFF_CTRL, {30'h0, fs, 1'b0});
    wr(OFF_MASK, {29'h0, m});
    lm.req();
    rec(0);
    chk("byte0 waiting", q, {25'h0, fs, 6'h02});
    lm.send(1, 8'hA5, 1'b0);
    lm.exe();
    rec(0);
    chk("byte0 executing", q, {25'h0, fs, 6'h03});
    lm.send(n, b, s);
    rec(0);
    chk("byte0 before done", q, {25'h0, fs, 6'h03});
    lm.finish(f, c, d, g);
    rec(0);
    chk("byte0 final", q, {25'h0, fs, 3'h0, code});
    chk("fast request", {31'h0, fast_seq_req}, {31'h0, fs});
    chk("irq level", {31'h0, irq}, {31'h0, (m[0] & ~f) | (m[1] & f) | (m[2] & ov)});
    rec(1);
    chk("group byte", q, {24'h0, (f && c <= 4'h8) ? c : 4'h0, 1'b0, g});
    if (f) begin
      rec(2);
      chk("detail byte", q, {24'h0, exp_det(c, d)});
    end
    for (int k = 0; k < nk; k++) begin
      rec(k + hdr);
      chk("frame byte", q, {24'h0, b + 8'(k * 37)});
    end
    rd(OFF_LEN);
    chk("length", q, 32'(hdr + nk));
    rd(OFF_STATUS);
    chk("status", q, {29'h0, ov, f, 1'b1});
    rd(OFF_STATUS);
    chk("status cleared", q, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    final_report();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] t;
    logic        f;
    logic [3:0]  c;
    logic [7:0]  d;
    failures = 0;
    n_compared = 0;
    seed = 32'h7;
    resetn = 1'b0;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    chk("irq at reset", {31'h0, irq}, 32'h0);
    rec(0);
    chk("byte0 idle", q, 32'h0);
    rd(OFF_LEN);
    chk("length idle", q, 32'h2);
    rd(12'h010);
    chk("unmapped read", q, 32'h0);
    bus(1'b1, OFF_MASK, 32'h7, 4'h0);
    rd(OFF_MASK);
    chk("mask lane off", q, 32'h0);
    // first sixteen walk every class, 9 to 15 included
    for (int i = 0; i < 40; i++) begin
      r = xs();
      t = xs();
      f = (i < 16) ? 1'b1 : t[0];
      c = (i < 16) ? 4'(i) : t[4:1];
      d = (c == 4'h1 || c == 4'h2) ? 8'(t % 6) : (c == 4'h6) ? 8'(t % 5) : t[15:8];
      xfer(f, c, d, r[17:15], int'(r[10:9]), r[11], r[12], {1'b0, r[14:13]});
    end
    xfer(1'b0, 4'h0, 8'h00, 3'h0, 240, 1'b0, 1'b1, 3'h4);
    wr(OFF_CTRL, 32'h1);
    rec(0);
    chk("byte0 cleared", q, 32'h0);
    rd(OFF_CTRL);
    chk("ctrl clear reads 0", q, 32'h0);
    rec(240);
    chk("beyond record", q, 32'h0);
    final_report();
  end
endmodule
